/* rtl/spa_defs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 40 MHz hclk, AHB-Lite word registers
// Notes:   included by the strap and pins design files of the pin block
`ifndef SPA_DEFS_SVH
`define SPA_DEFS_SVH

// timing
`define SPA_CLK_PERIOD_NS    25
`define SPA_STRAP_SETTLE_NS  1000
`define SPA_STRAP_CYCLES \
    ((`SPA_STRAP_SETTLE_NS + `SPA_CLK_PERIOD_NS - 1) / `SPA_CLK_PERIOD_NS)

// register byte offsets
`define SPA_FUNC_SEL_OFS     8'h00
`define SPA_GPIO_OUT_OFS     8'h04
`define SPA_GPIO_OE_OFS      8'h08
`define SPA_PIN_STAT_OFS     8'h0c
`define SPA_GLOBAL_OPT_OFS   8'h10
`define SPA_CONFIG_OPT_OFS   8'h14
`define SPA_CONFIG_ADDR_OFS  8'h18

// reset values
`define SPA_FUNC_SEL_RST     7'h00
`define SPA_GPIO_OUT_RST     7'h00
`define SPA_GPIO_OE_RST      7'h00
`define SPA_CONFIG_ADDR_LO   8'h2e
`define SPA_CONFIG_ADDR_HI   8'h4e

// field positions
`define SPA_KBD_EN_BIT       2
`define SPA_ROM_EN_BIT       1
`define SPA_CFG_SEL_BIT      6
`define SPA_STAT_DONE_BIT    8

// pin positions on the shared port
`define SPA_PIN_RING         0
`define SPA_PIN_CARRIER      1
`define SPA_PIN_TX           2
`define SPA_PIN_RX           3
`define SPA_PIN_DTR          4
`define SPA_PIN_RTS          5
`define SPA_PIN_DSR          6

// pin classes
`define SPA_OD_MASK          7'h4b
`define SPA_SER_OUT_MASK     7'h34
`define SPA_STRAP_MASK       7'h34

`endif

/* rtl/spa_pkg.sv */
// Purpose: types shared by the serial port pin block
// Assumes: nothing beyond the defines header
// Notes:   one-hot state codes written out
package spa_pkg;

    typedef enum logic [1:0] {
        SPA_SETTLE = 2'b01,
        SPA_RUN    = 2'b10
    } spa_state_t;

    typedef struct packed {
        logic ring_present;
        logic carrier_present;
        logic set_ready_present;
        logic rx;
    } spa_modem_in_t;

    typedef struct packed {
        logic tx;
        logic terminal_ready;
        logic request_send;
    } spa_modem_out_t;

    typedef struct packed {
        logic cfg_sel;
        logic rom_en;
        logic kbd_en;
    } spa_strap_t;

endpackage : spa_pkg

/* rtl/spa_sync.sv */
// Purpose: two-flop synchroniser for pad inputs
// Assumes: inputs asynchronous to hclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module spa_sync #(
    parameter int W = 7
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // per-bit two stage capture; reset to the idle high line level so
    // no false modem presence shows right after reset
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                meta[i] <= 1'b1;
                q[i]    <= 1'b1;
            end else begin
                meta[i] <= d[i];
                q[i]    <= meta[i];
            end
        end
    end
endmodule : spa_sync

/* rtl/spa_strap.sv */
// Purpose: strap settle, capture and release after power-on reset
// Assumes: strap levels arrive already synchronised
// Notes:   pulldowns stay on from reset until capture
`timescale 1ns/100ps
`include "spa_defs.svh"
module spa_strap
    import spa_pkg::*;
#(
    parameter int SETTLE_CYCLES = `SPA_STRAP_CYCLES
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire spa_strap_t lvl,
    output spa_strap_t      cap,
    output logic            load,
    output logic            done,
    output logic            pd_on
);
    spa_state_t  state;
    logic [15:0] cnt;

    // settle then capture once, then hold for good
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= SPA_SETTLE;
            cnt   <= 16'(SETTLE_CYCLES - 1);
            load  <= 1'b0;
        end else begin
            load <= 1'b0;
            unique case (state)
                SPA_SETTLE: begin
                    if (cnt == 16'h0000) begin
                        state <= SPA_RUN;
                        load  <= 1'b1;
                    end else begin
                        cnt <= cnt - 16'h0001;
                    end
                end
                SPA_RUN: state <= SPA_RUN;
                default: state <= SPA_SETTLE;
            endcase
        end
    end

    // captured strap levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap <= '0;
        end else if (state == SPA_SETTLE && cnt == 16'h0000) begin
            cap <= lvl;
        end
    end

    // pulldowns on through reset and settle, off once captured
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_on    <= 1'b1;
            done     <= 1'b0;
        end else begin
            pd_on    <= (state == SPA_SETTLE) && (cnt != 16'h0000);
            done     <= done || (state == SPA_SETTLE && cnt == 16'h0000);
        end
    end

    property p_capture;
        @(posedge hclk) disable iff (!hresetn)
        (state == SPA_SETTLE && cnt == 16'h0000) |=> load && cap == $past(lvl);
    endproperty
    a_capture: assert property (p_capture)
        else $error("strap levels not captured at end of settle");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        done |=> done && !pd_on && $stable(cap) && !load;
    endproperty
    a_hold: assert property (p_hold)
        else $error("strap capture not held after release");

    property p_settle_len;
        @(posedge hclk) disable iff (!hresetn)
        $rose(load) |-> $past(pd_on, 2) && !$past(done);
    endproperty
    a_settle_len: assert property (p_settle_len)
        else $error("strap captured without pulldown settle");
endmodule : spa_strap

/* rtl/spa_pins.sv */
// Purpose: first serial port modem pins shared with gpio port 6 and straps
// Assumes: AHB-Lite slave, single word transfers, one clock hclk
// Notes:   pads are in, out and oe; pulldown is the strap pulldown enable
//
// How it works
// - terminal-ready output driven low when the controller is ready
// - request-send output driven low when ready to send data
// - transmit serial data leaves on the serial output pin
// - receive serial data enters on the serial input pin
// - each pin serves either serial/strap function or gpio port 6
// - keyboard strap pulled down in reset, sets global option bit 2
// - keyboard strap low powers up with keyboard controller disabled
// - rom strap pulled down in reset, sets global option bit 1
// - rom strap low disables serial flash; high enables the rom
// - config strap pulled down in reset, sets config option bit 6
// - config strap low selects port 2eh, high selects 4eh
`timescale 1ns/100ps
`include "spa_defs.svh"
module spa_pins
    import spa_pkg::*;
#(
    parameter int PINS          = 7,
    parameter int SETTLE_CYCLES = `SPA_STRAP_CYCLES
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic [31:0]          hrdata,
    output logic                 hresp,
    input  wire logic [PINS-1:0] pad_in,
    output logic      [PINS-1:0] pad_out,
    output logic      [PINS-1:0] pad_oe,
    output logic      [PINS-1:0] pad_pulldown,
    input  wire spa_modem_out_t  uart_out,
    output spa_modem_in_t        uart_in,
    output logic                 kbd_ctrl_enable,
    output logic                 rom_enable_bit,
    output logic                 config_addr_select,
    output logic [7:0]           config_port_addr
);
    logic [PINS-1:0] pad_s;
    logic [PINS-1:0] func_sel;
    logic [PINS-1:0] gpio_out;
    logic [PINS-1:0] gpio_oe;
    logic [7:0]      global_option_register;
    logic [7:0]      config_option_register;
    logic [PINS-1:0] ser_val;
    logic [PINS-1:0] next_out;
    logic [PINS-1:0] next_oe;
    logic [31:0]     next_rdata;
    logic [7:0]      ap_addr;
    logic            wr_dp;
    logic            rd_wait;
    logic            addr_ok;
    logic            strap_load;
    logic            strap_done;
    logic            strap_pd;
    spa_strap_t      strap_lvl;
    spa_strap_t      strap_cap;

    // pad inputs cross into hclk
    spa_sync #(
        .W (PINS)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (pad_in),
        .q       (pad_s)
    );

    // strap levels come from the synchronised pads
    assign strap_lvl.kbd_en  = pad_s[`SPA_PIN_TX];
    assign strap_lvl.rom_en  = pad_s[`SPA_PIN_DTR];
    assign strap_lvl.cfg_sel = pad_s[`SPA_PIN_RTS];

    spa_strap #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_strap (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .lvl      (strap_lvl),
        .cap      (strap_cap),
        .load     (strap_load),
        .done     (strap_done),
        .pd_on    (strap_pd)
    );

    // bus slave: writes complete with no wait, reads with one wait state
    assign addr_ok   = hsel && hready && htrans[1];
    assign hreadyout = !rd_wait;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_addr <= 8'h00;
            wr_dp   <= 1'b0;
            rd_wait <= 1'b0;
        end else begin
            wr_dp   <= addr_ok && hwrite;
            rd_wait <= addr_ok && !hwrite;
            if (addr_ok) begin
                ap_addr <= haddr[7:0];
            end
        end
    end

    // pin function select, 1 hands the pin to gpio port 6
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            func_sel <= `SPA_FUNC_SEL_RST;
        end else if (wr_dp && ap_addr == `SPA_FUNC_SEL_OFS) begin
            func_sel <= hwdata[PINS-1:0];
        end
    end

    // gpio output level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gpio_out <= `SPA_GPIO_OUT_RST;
        end else if (wr_dp && ap_addr == `SPA_GPIO_OUT_OFS) begin
            gpio_out <= hwdata[PINS-1:0];
        end
    end

    // gpio output enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gpio_oe <= `SPA_GPIO_OE_RST;
        end else if (wr_dp && ap_addr == `SPA_GPIO_OE_OFS) begin
            gpio_oe <= hwdata[PINS-1:0];
        end
    end

    // global options: strap value at power-on, software may change later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_option_register <= 8'h00;
        end else if (strap_load) begin
            global_option_register[`SPA_KBD_EN_BIT] <= strap_cap.kbd_en;
            global_option_register[`SPA_ROM_EN_BIT] <= strap_cap.rom_en;
        end else if (wr_dp && ap_addr == `SPA_GLOBAL_OPT_OFS) begin
            global_option_register <= hwdata[7:0];
        end
    end

    // config options: address select bit from the strap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_option_register <= 8'h00;
        end else if (strap_load) begin
            config_option_register[`SPA_CFG_SEL_BIT] <= strap_cap.cfg_sel;
        end else if (wr_dp && ap_addr == `SPA_CONFIG_OPT_OFS) begin
            config_option_register <= hwdata[7:0];
        end
    end

    assign kbd_ctrl_enable    = global_option_register[`SPA_KBD_EN_BIT];
    assign rom_enable_bit     = global_option_register[`SPA_ROM_EN_BIT];
    assign config_addr_select = config_option_register[`SPA_CFG_SEL_BIT];

    // configuration port address follows the select bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_port_addr <= `SPA_CONFIG_ADDR_LO;
        end else if (config_addr_select) begin
            config_port_addr <= `SPA_CONFIG_ADDR_HI;
        end else begin
            config_port_addr <= `SPA_CONFIG_ADDR_LO;
        end
    end

    // read mux, unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (ap_addr)
            `SPA_FUNC_SEL_OFS:    next_rdata[PINS-1:0] = func_sel;
            `SPA_GPIO_OUT_OFS:    next_rdata[PINS-1:0] = gpio_out;
            `SPA_GPIO_OE_OFS:     next_rdata[PINS-1:0] = gpio_oe;
            `SPA_PIN_STAT_OFS: begin
                next_rdata[PINS-1:0]          = pad_s;
                next_rdata[`SPA_STAT_DONE_BIT] = strap_done;
            end
            `SPA_GLOBAL_OPT_OFS:  next_rdata[7:0] = global_option_register;
            `SPA_CONFIG_OPT_OFS:  next_rdata[7:0] = config_option_register;
            `SPA_CONFIG_ADDR_OFS: next_rdata[7:0] = config_port_addr;
            default:              next_rdata = 32'h0000_0000;
        endcase
    end

    // read data loads during the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_wait) begin
            hrdata <= next_rdata;
        end
    end

    // serial function levels, modem controls active low on the pins
    always_comb begin
        ser_val                = '0;
        ser_val[`SPA_PIN_TX]   = uart_out.tx;
        ser_val[`SPA_PIN_DTR]  = !uart_out.terminal_ready;
        ser_val[`SPA_PIN_RTS]  = !uart_out.request_send;
    end

    // per-pin mux; open-drain gpio pins only pull low
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        localparam logic [6:0] OD_MASK  = `SPA_OD_MASK;
        localparam logic [6:0] SER_MASK = `SPA_SER_OUT_MASK;
        localparam logic       OD       = OD_MASK[i];
        localparam logic       SER      = SER_MASK[i];
        always_comb begin
            if (func_sel[i]) begin
                next_out[i] = OD ? 1'b0 : gpio_out[i];
                next_oe[i]  = strap_done &&
                              (OD ? (gpio_oe[i] && !gpio_out[i])
                                  : gpio_oe[i]);
            end else begin
                next_out[i] = ser_val[i];
                next_oe[i]  = strap_done && SER;
            end
        end
    end

    // registered pad drive; strap pins float with pulldowns until capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out      <= '0;
            pad_oe       <= '0;
            pad_pulldown <= `SPA_STRAP_MASK;
        end else begin
            pad_out      <= next_out;
            pad_oe       <= next_oe;
            pad_pulldown <= strap_pd ? `SPA_STRAP_MASK : '0;
        end
    end

    // modem status into the uart; idle when the pin serves gpio
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uart_in <= '{ring_present: 1'b0, carrier_present: 1'b0,
                         set_ready_present: 1'b0, rx: 1'b1};
        end else begin
            uart_in.ring_present      <= !func_sel[`SPA_PIN_RING] &&
                                         !pad_s[`SPA_PIN_RING];
            uart_in.carrier_present   <= !func_sel[`SPA_PIN_CARRIER] &&
                                         !pad_s[`SPA_PIN_CARRIER];
            uart_in.set_ready_present <= !func_sel[`SPA_PIN_DSR] &&
                                         !pad_s[`SPA_PIN_DSR];
            uart_in.rx                <= func_sel[`SPA_PIN_RX] ||
                                         pad_s[`SPA_PIN_RX];
        end
    end

    property p_dtr;
        @(posedge hclk) disable iff (!hresetn)
        strap_done && !func_sel[`SPA_PIN_DTR] |=>
            pad_oe[`SPA_PIN_DTR] &&
            pad_out[`SPA_PIN_DTR] == !$past(uart_out.terminal_ready);
    endproperty
    a_dtr: assert property (p_dtr)
        else $error("terminal ready pin not low-active copy of request");

    property p_rts;
        @(posedge hclk) disable iff (!hresetn)
        strap_done && !func_sel[`SPA_PIN_RTS] |=>
            pad_oe[`SPA_PIN_RTS] &&
            pad_out[`SPA_PIN_RTS] == !$past(uart_out.request_send);
    endproperty
    a_rts: assert property (p_rts)
        else $error("request send pin not low-active copy of request");

    property p_tx;
        @(posedge hclk) disable iff (!hresetn)
        strap_done && !func_sel[`SPA_PIN_TX] |=>
            pad_oe[`SPA_PIN_TX] && pad_out[`SPA_PIN_TX] == $past(uart_out.tx);
    endproperty
    a_tx: assert property (p_tx)
        else $error("serial output pin does not follow transmit data");

    // input checks skip edges whose three-deep history reaches into reset
    property p_rx;
        @(posedge hclk) disable iff (!hresetn)
        $past(hresetn, 3) && !func_sel[`SPA_PIN_RX] &&
            !$past(func_sel[`SPA_PIN_RX]) |->
            uart_in.rx == $past(pad_in[`SPA_PIN_RX], 3);
    endproperty
    a_rx: assert property (p_rx)
        else $error("receive data not three cycles behind serial input");

    property p_ring;
        @(posedge hclk) disable iff (!hresetn)
        $past(hresetn, 3) && !func_sel[`SPA_PIN_RING] &&
            !$past(func_sel[`SPA_PIN_RING]) |->
            uart_in.ring_present == !$past(pad_in[`SPA_PIN_RING], 3);
    endproperty
    a_ring: assert property (p_ring)
        else $error("ring present does not follow low ring input");

    property p_carrier;
        @(posedge hclk) disable iff (!hresetn)
        $past(hresetn, 3) && !func_sel[`SPA_PIN_CARRIER] &&
            !$past(func_sel[`SPA_PIN_CARRIER])
            |-> uart_in.carrier_present ==
                !$past(pad_in[`SPA_PIN_CARRIER], 3);
    endproperty
    a_carrier: assert property (p_carrier)
        else $error("carrier present does not follow low carrier input");

    property p_gpio_in_pin;
        @(posedge hclk) disable iff (!hresetn)
        strap_done && func_sel[`SPA_PIN_DSR] && gpio_oe[`SPA_PIN_DSR] &&
            !gpio_out[`SPA_PIN_DSR] |=>
            pad_oe[`SPA_PIN_DSR] && !pad_out[`SPA_PIN_DSR];
    endproperty
    a_gpio_in_pin: assert property (p_gpio_in_pin)
        else $error("gpio open-drain pin not pulled low when asked");

    property p_release;
        @(posedge hclk) disable iff (!hresetn)
        !strap_done |=> pad_oe == '0;
    endproperty
    a_release: assert property (p_release)
        else $error("pad driven before strap capture completed");

    property p_cfg_addr;
        @(posedge hclk) disable iff (!hresetn)
        $past(strap_load) ##1 1'b1 |->
            config_port_addr == ($past(config_addr_select)
                                 ? `SPA_CONFIG_ADDR_HI : `SPA_CONFIG_ADDR_LO);
    endproperty
    a_cfg_addr: assert property (p_cfg_addr)
        else $error("configuration address does not match select bit");

    property p_kbd_strap;
        @(posedge hclk) disable iff (!hresetn)
        strap_load |=> kbd_ctrl_enable == $past(strap_cap.kbd_en) &&
                       rom_enable_bit == $past(strap_cap.rom_en);
    endproperty
    a_kbd_strap: assert property (p_kbd_strap)
        else $error("power-on option bits do not match captured straps");
endmodule : spa_pins

/* bench/spa_modem.sv */
// Purpose: modem and strap resistors seen at the shared port pins
// Assumes: presence inputs active high, pins active low on the wire
// Notes:   open-drain pins wire-and with the modem drive
`timescale 1ns/100ps
module spa_modem (
    input  wire logic [6:0] pad_out,
    input  wire logic [6:0] pad_oe,
    input  wire logic [2:0] strap,
    input  wire logic       ring,
    input  wire logic       carrier,
    input  wire logic       ready,
    input  wire logic       rx,
    output logic      [6:0] pad_in
);
    logic [6:0] ext;

    // modem drives low for presence, straps via board resistors
    assign ext = {~ready, strap[2], strap[1], rx, strap[0],
                  ~carrier, ~ring};
    // resolve each wire from both parties
    assign pad_in = (ext & ~(pad_oe & ~pad_out) & 7'h4b)
                  | (((pad_oe & pad_out) | (~pad_oe & ext)) & 7'h34);
endmodule : spa_modem

/* bench/serial_port_a_pins_and_straps_tb.sv */
// Purpose: self-checking bench for the serial port pin block
// Assumes: short strap settle, random values from an lfsr
// Notes:   straps, modem lines, gpio mode and the register bus
`timescale 1ns/100ps
module serial_port_a_pins_and_straps_tb;
    import spa_pkg::*;
    localparam int SC = 4;
    logic           hclk = 1'b0;
    logic           hresetn = 1'b0;
    logic           hsel = 1'b0;
    logic [31:0]    haddr = 32'h0;
    logic [1:0]     htrans = 2'b00;
    logic           hwrite = 1'b0;
    logic [31:0]    hwdata = 32'h0;
    logic           hreadyout;
    logic [31:0]    hrdata;
    logic           hresp;
    logic [6:0]     pad_in, pad_out, pad_oe, pad_pulldown;
    spa_modem_out_t uo = '0;
    spa_modem_in_t  ui;
    logic           kbd, rom, cfg;
    logic [7:0]     cport;
    logic [2:0]     strap = 3'b000;
    logic [3:0]     mdm = 4'h0;
    logic [15:0]    lf;
    logic [31:0]    rd;
    int             errors = 0;
    int             n_checks = 0;

    always #12.5 hclk = ~hclk;

    spa_pins #(.PINS(7), .SETTLE_CYCLES(SC)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pulldown(pad_pulldown), .uart_out(uo), .uart_in(ui),
        .kbd_ctrl_enable(kbd), .rom_enable_bit(rom),
        .config_addr_select(cfg), .config_port_addr(cport));

    spa_modem u_modem (
        .pad_out(pad_out), .pad_oe(pad_oe), .strap(strap),
        .ring(mdm[0]), .carrier(mdm[1]), .ready(mdm[2]), .rx(mdm[3]),
        .pad_in(pad_in));

    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // expected {pad_out, pad_oe} in gpio mode
    function logic [13:0] gexp(input logic [6:0] o, input logic [6:0] e);
        return {o & 7'h34, (e & ~o & 7'h4b) | (e & 7'h34)};
    endfunction : gexp

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task ahb_wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : ahb_wr

    task ahb_rd(input logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : ahb_rd

    // reset with given straps, then check capture and release
    task run_reset(input logic [2:0] s);
        hresetn <= 1'b0;
        strap <= s;
        repeat (3) @(posedge hclk);
        chk("pulldown", 32'h34, {25'h0, pad_pulldown});
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("oe_settle", 32'h0, {25'h0, pad_oe});
        rd = 32'h0;
        while (rd[8] !== 1'b1) ahb_rd(8'h0c, rd);
        repeat (2) @(posedge hclk);
        chk("pulldown_off", 32'h0, {25'h0, pad_pulldown});
        chk("kbd_en", {31'h0, s[0]}, {31'h0, kbd});
        chk("rom_en", {31'h0, s[1]}, {31'h0, rom});
        chk("cfg_sel", {31'h0, s[2]}, {31'h0, cfg});
        chk("cport", s[2] ? 32'h4e : 32'h2e, {24'h0, cport});
        ahb_rd(8'h10, rd);
        chk("global_opt", {29'h0, s[0], s[1], 1'b0}, rd);
        ahb_rd(8'h14, rd);
        chk("config_opt", {25'h0, s[2], 6'h0}, rd);
        ahb_rd(8'h18, rd);
        chk("cfg_addr_reg", s[2] ? 32'h4e : 32'h2e, rd);
        $display("test strap %b done", s);
    endtask : run_reset

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // main sequence
    initial begin
        lf = 16'h1b05;
        for (int k = 0; k < 3; k++) begin
            lf = lfsr(lf);
            run_reset(k == 0 ? 3'b000 : k == 1 ? 3'b111 : lf[2:0]);
        end
        for (int k = 0; k < 8; k++) begin
            lf = lfsr(lf);
            mdm <= lf[3:0];
            uo <= lf[6:4];
            repeat (5) @(posedge hclk);
            chk("uart_in", {28'h0, lf[0], lf[1], lf[2], lf[3]},
                {28'h0, ui});
            chk("ser_out", {25'h0, 1'b0, ~lf[4], ~lf[5], 1'b0, lf[6], 2'b0},
                {25'h0, pad_out & 7'h34});
            chk("ser_oe", 32'h34, {25'h0, pad_oe});
        end
        $display("test modem lines done");
        ahb_wr(8'h00, 32'h7f);
        for (int k = 0; k < 4; k++) begin
            lf = lfsr(lf);
            // corner: every pin enabled and driven low
            if (k == 0) lf[13:0] = 14'h3f80;
            ahb_wr(8'h04, {25'h0, lf[6:0]});
            ahb_wr(8'h08, {25'h0, lf[13:7]});
            ahb_rd(8'h04, rd);
            chk("gpio_out_reg", {25'h0, lf[6:0]}, rd);
            repeat (4) @(posedge hclk);
            chk("gpio_pads", {18'h0, gexp(lf[6:0], lf[13:7])},
                {18'h0, pad_out, pad_oe});
            chk("gpio_uart_in", 32'h1, {28'h0, ui});
        end
        ahb_rd(8'h1c, rd);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        ahb_wr(8'h14, 32'h40);
        repeat (2) @(posedge hclk);
        chk("cport_sw", 32'h4e, {24'h0, cport});
        ahb_wr(8'h00, 32'h0);
        repeat (2) @(posedge hclk);
        chk("back_serial", 32'h34, {25'h0, pad_oe});
        $display("test gpio mode done");
        end_sim;
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        end_sim;
    end
endmodule : serial_port_a_pins_and_straps_tb
